// *** design/ubdo_defs.svh ***
// Purpose: Constants of the descriptor ownership block: bit positions, offsets, reset values.
// Assumes: Included by its bare name from every file that needs a figure.
// Notes:   Definitions only.
`ifndef UBDO_DEFS_SVH
`define UBDO_DEFS_SVH

// Status byte fields, same positions in both views where shared.
`define UBDO_OWN_BIT      7
`define UBDO_DTS_BIT      6
`define UBDO_RSV_HI       5
`define UBDO_RSV_LO       4
`define UBDO_TOGGLE_CHECK_ENABLE_BIT    3
`define UBDO_BUFFER_STALL_ENABLE_BIT   2
`define UBDO_PID_HI       5
`define UBDO_PID_LO       2
`define UBDO_CNT_HI       1
`define UBDO_CNT_LO       0

// Token packet identifiers as they travel on the bus.
`define UBDO_PID_OUT      4'h1
`define UBDO_PID_IN       4'h9
`define UBDO_PID_SETUP    4'hd

// Descriptor window: paddr[11:9] selects it, paddr[8:3] the descriptor, paddr[2] count byte.
`define UBDO_DESC_REGION  3'h0
`define UBDO_DESC_CNT_SEL 2

// Control and status registers.
`define UBDO_OFF_INT_STAT 12'h200
`define UBDO_OFF_INT_MASK 12'h204
`define UBDO_OFF_EP_STALL 12'h208
`define UBDO_OFF_CTRL     12'h20c
`define UBDO_OFF_LAST     12'h210

// Interrupt status and mask layout.
`define UBDO_INT_W        3
`define UBDO_INT_DONE     0
`define UBDO_INT_STALL    1
`define UBDO_INT_MISMATCH 2

// Control register layout.
`define UBDO_CTRL_KEEP    0

// Reset values.
`define UBDO_RST_INT      3'h0
`define UBDO_RST_EP       16'h0000
`define UBDO_RST_KEEP     1'b0
`define UBDO_RST_LAST     12'h000

`endif

// *** design/ubdo_pkg.sv ***
// Purpose: Types shared by the descriptor ownership block.
// Assumes: Nothing beyond the constants header.
// Notes:   Handshake codes are an enum with default encoding, 0 to 3 in the order listed.
package ubdo_pkg;

   // Handshake the engine returns for a token.
   typedef enum logic [1:0] {
      hs_none,
      hs_ack,
      hs_nak,
      hs_stall
   } ubdo_hs_t;

endpackage : ubdo_pkg

// *** design/ubdo_eval_if.sv ***
// Purpose: Carries one token and its descriptor to the evaluator and the verdict back.
// Assumes: The evaluator is purely combinational.
// Notes:   Used only between the top module and its evaluator.
`timescale 1ns/100ps
interface ubdo_eval_if;
   import ubdo_pkg::*;

   logic [7:0] status;
   logic [7:0] count;
   logic [3:0] pid;
   logic       odd;
   logic       err;
   logic [9:0] len;
   logic       keep;
   ubdo_hs_t   hs;
   logic [7:0] new_status;
   logic [7:0] new_count;
   logic       upd;
   logic       buf_wr;
   logic       ev_done;
   logic       ev_stall;
   logic       ev_mismatch;

   // Evaluator side.
   modport eval (input status, count, pid, odd, err, len, keep,
                 output hs, new_status, new_count, upd, buf_wr, ev_done, ev_stall, ev_mismatch);
   // Register file side.
   modport ctrl (output status, count, pid, odd, err, len, keep,
                 input hs, new_status, new_count, upd, buf_wr, ev_done, ev_stall, ev_mismatch);
endinterface : ubdo_eval_if

// *** design/ubdo_eval.sv ***
// Purpose: Decides the handshake and the descriptor update for one token.
// Assumes: Inputs are the descriptor as stored when the token is taken.
// Notes:   Combinational; the caller registers every result.
`timescale 1ns/100ps
`include "ubdo_defs.svh"
module ubdo_eval
   import ubdo_pkg::*;
(
   // Token and descriptor in, verdict out.
   ubdo_eval_if.eval ev
);

   ////////////////////////////////////////////////////////////////////////////////
   // Decision, in priority order: ownership, stall, error, overflow, toggle, accept.
   always_comb begin
      logic is_rx;
      logic [9:0] limit;
      is_rx          = (ev.pid != `UBDO_PID_IN);
      limit          = {ev.status[`UBDO_CNT_HI:`UBDO_CNT_LO], ev.count};
      ev.hs          = hs_nak;
      ev.new_status  = ev.status;
      ev.new_count   = ev.count;
      ev.upd         = 1'b0;
      ev.buf_wr      = 1'b0;
      ev.ev_done     = 1'b0;
      ev.ev_stall    = 1'b0;
      ev.ev_mismatch = 1'b0;
      if (!ev.status[`UBDO_OWN_BIT]) begin
         ev.hs = hs_nak; // Core owns it; the engine leaves it alone.
      end else if (ev.status[`UBDO_BUFFER_STALL_ENABLE_BIT] && ev.pid != `UBDO_PID_SETUP) begin
         ev.hs       = hs_stall;
         ev.ev_stall = 1'b1;     // Descriptor stays as it is.
      end else if (ev.err) begin
         ev.hs = hs_nak;
      end else if (is_rx && ev.len > limit) begin
         ev.hs = hs_nak; // More data than the buffer holds; nothing updated.
      end else if (is_rx && ev.status[`UBDO_TOGGLE_CHECK_ENABLE_BIT] && ev.odd != ev.status[`UBDO_DTS_BIT]) begin
         ev.hs          = hs_ack; // Data dropped, ownership kept, still acknowledged.
         ev.ev_mismatch = 1'b1;
      end else begin
         // Toggle value plays no part when checking is off.
         ev.hs      = hs_ack;
         ev.upd     = 1'b1;
         ev.buf_wr  = is_rx;
         ev.ev_done = 1'b1;
         // Engine view: ownership, untouched bit 6, token PID, count high bits.
         ev.new_status[`UBDO_OWN_BIT]                = ev.keep && !ev.status[`UBDO_BUFFER_STALL_ENABLE_BIT];
         ev.new_status[`UBDO_PID_HI:`UBDO_PID_LO]    = ev.pid;
         ev.new_status[`UBDO_CNT_HI:`UBDO_CNT_LO]    = ev.len[9:8];
         ev.new_count                                = ev.len[7:0];
      end
   end

endmodule : ubdo_eval

// *** design/ubdo_top.sv ***
// Purpose: Buffer descriptor table with ownership handshake, seen by software over APB
//          and by the serial interface engine through a token port.
// Assumes: Token inputs are synchronous to pclk; tok_desc is below NUM_DESC.
// Notes:   Descriptor bytes have no reset value, like the shared RAM they model.
//
// Function
// - Status bit 7 is the ownership flag deciding who may update the descriptor.
// - Core can read the status byte while the engine owns it, and vice versa.
// - Once engine owns it, it writes token PID and transfer count into the descriptor.
// - Engine clears ownership on completion, unless keep-ownership is on and buffer stall is off.
// - Core accesses to engine-owned descriptors are not blocked; results may be wrong.
// - With toggle check on, received data parity is compared with the expected toggle bit.
// - Toggle mismatch: data dropped, no done flag, ownership kept, ACK still sent.
// - Good toggle or no check: ACK, release, done flag, update; errored packet: NAK.
// - Buffer stall on: any token but SETUP using the descriptor is answered with STALL.
// - Each STALL sets the endpoint stall indicator and raises a stall interrupt.
// - During stall descriptor stays owned and unchanged; SETUP clears stall and releases.
// - Status bits 1:0 hold count bits 9:8; count byte holds bits 7:0.
// - Byte count is 10 bits, 0 to 1023: bytes to send or most to accept.
// - Engine view bits 5:2 report the PID of the last IN, OUT or SETUP token.
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "ubdo_defs.svh"
module ubdo_top
   import ubdo_pkg::*;
#(
   parameter int NUM_DESC = 64
)
(
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Token port from the serial interface engine.
   input  wire logic        tok_valid,
   input  wire logic [3:0]  tok_pid,
   input  wire logic [5:0]  tok_desc,
   input  wire logic [3:0]  tok_ep,
   input  wire logic        tok_odd,
   input  wire logic        tok_err,
   input  wire logic [9:0]  tok_len,
   // Verdict back to the engine.
   output logic             hs_valid,
   output ubdo_hs_t         hs_code,
   output logic             buf_wr_en,
   // Interrupt.
   output logic             irq
);

   ////////////////////////////////////////////////////////////////////////////////
   // Storage and registers.
   logic [7:0]             status_mem [NUM_DESC];
   logic [7:0]             count_mem  [NUM_DESC];
   logic                   pready_r;
   logic [31:0]            prdata_r;
   logic                   pslverr_r;
   logic [`UBDO_INT_W-1:0] int_stat_r;
   logic [`UBDO_INT_W-1:0] int_mask_r;
   logic [15:0]            ep_stall_r;
   logic                   keep_r;
   logic [11:0]            last_r;
   logic                   hs_valid_r;
   ubdo_hs_t               hs_code_r;
   logic                   buf_wr_r;
   logic                   irq_r;
   logic [3:0]             last_ep_r;

   logic                   acc_phase;
   logic                   wr_fire;
   logic [5:0]             a_idx;
   logic [31:0]            rd_mux;
   logic [`UBDO_INT_W-1:0] int_set;
   logic [7:0]             status_rd;

   ubdo_eval_if ev ();

   ////////////////////////////////////////////////////////////////////////////////
   // Address decoding, used for reads, writes and the error answer.
   function automatic logic is_desc(input logic [11:0] a);
      return (a[11:9] == `UBDO_DESC_REGION) && (32'(a[8:3]) < NUM_DESC);
   endfunction : is_desc

   function automatic logic is_mapped(input logic [11:0] a);
      logic [11:0] w;
      w = {a[11:2], 2'b00};
      return is_desc(a) || w == `UBDO_OFF_INT_STAT || w == `UBDO_OFF_INT_MASK ||
             w == `UBDO_OFF_EP_STALL || w == `UBDO_OFF_CTRL || w == `UBDO_OFF_LAST;
   endfunction : is_mapped

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      return {a[11:2], 2'b00} == off;
   endfunction : hit

   // One wait state: the first access cycle prepares the answer, the second completes it.
   assign acc_phase = psel && penable && !pready_r;
   assign wr_fire   = psel && penable && pready_r && pwrite;
   assign a_idx     = paddr[8:3];
   assign status_rd = status_mem[tok_desc];

   ////////////////////////////////////////////////////////////////////////////////
   // Evaluator hookup.
   assign ev.status = status_rd;
   assign ev.count  = count_mem[tok_desc];
   assign ev.pid    = tok_pid;
   assign ev.odd    = tok_odd;
   assign ev.err    = tok_err;
   assign ev.len    = tok_len;
   assign ev.keep   = keep_r;

   ubdo_eval u_eval (
      .ev (ev.eval)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Read multiplexer; status bytes read back whoever owns them.
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (is_desc(paddr)) begin
         if (paddr[`UBDO_DESC_CNT_SEL]) begin
            rd_mux = {24'h00_0000, count_mem[a_idx]};
         end else begin
            rd_mux = {24'h00_0000, status_mem[a_idx]}; // No ownership check on reads.
         end
      end else if (hit(paddr, `UBDO_OFF_INT_STAT)) begin
         rd_mux = {29'h0000_0000, int_stat_r};
      end else if (hit(paddr, `UBDO_OFF_INT_MASK)) begin
         rd_mux = {29'h0000_0000, int_mask_r};
      end else if (hit(paddr, `UBDO_OFF_EP_STALL)) begin
         rd_mux = {16'h0000, ep_stall_r};
      end else if (hit(paddr, `UBDO_OFF_CTRL)) begin
         rd_mux = {31'h0000_0000, keep_r};
      end else if (hit(paddr, `UBDO_OFF_LAST)) begin
         rd_mux = {20'h0_0000, last_r};
      end
   end

   // APB answer registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else begin
         pready_r  <= acc_phase;
         pslverr_r <= acc_phase && !is_mapped(paddr);
         prdata_r  <= (acc_phase && !pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Descriptor memory; the engine write comes last so it wins on the same byte.
   always_ff @(posedge pclk) begin
      if (wr_fire && is_desc(paddr)) begin
         // Writes to engine-owned descriptors go through unblocked.
         if (paddr[`UBDO_DESC_CNT_SEL]) begin
            count_mem[a_idx] <= pwdata[7:0];
         end else begin
            status_mem[a_idx] <= pwdata[7:0];
         end
      end
      if (tok_valid && ev.upd) begin
         status_mem[tok_desc] <= ev.new_status;
         count_mem[tok_desc]  <= ev.new_count;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Verdict registers toward the engine.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hs_valid_r <= 1'b0;
         hs_code_r  <= hs_none;
         buf_wr_r   <= 1'b0;
         last_ep_r  <= 4'h0;
      end else begin
         hs_valid_r <= tok_valid;
         hs_code_r  <= tok_valid ? ev.hs : hs_none;
         buf_wr_r   <= tok_valid && ev.buf_wr; // Dropped data is never written.
         if (tok_valid) begin
            last_ep_r <= tok_ep;
         end
      end
   end

   // Last token summary: handshake, PID and descriptor index.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_r <= `UBDO_RST_LAST;
      end else if (tok_valid) begin
         last_r <= {ev.hs, tok_pid, tok_desc};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Control register (keep ownership after completion) and interrupt mask.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         keep_r     <= `UBDO_RST_KEEP;
         int_mask_r <= `UBDO_RST_INT;
      end else if (wr_fire) begin
         if (hit(paddr, `UBDO_OFF_CTRL)) begin
            keep_r <= pwdata[`UBDO_CTRL_KEEP];
         end
         if (hit(paddr, `UBDO_OFF_INT_MASK)) begin
            int_mask_r <= pwdata[`UBDO_INT_W-1:0];
         end
      end
   end

   // Interrupt status: set by events, cleared by writing one; a set in the clear cycle wins.
   always_comb begin
      int_set                     = '0;
      int_set[`UBDO_INT_DONE]     = tok_valid && ev.ev_done;
      int_set[`UBDO_INT_STALL]    = tok_valid && ev.ev_stall;
      int_set[`UBDO_INT_MISMATCH] = tok_valid && ev.ev_mismatch; // No done flag here.
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_stat_r <= `UBDO_RST_INT;
      end else if (wr_fire && hit(paddr, `UBDO_OFF_INT_STAT)) begin
         int_stat_r <= (int_stat_r & ~pwdata[`UBDO_INT_W-1:0]) | int_set;
      end else begin
         int_stat_r <= int_stat_r | int_set;
      end
   end

   // Endpoint stall indicators, one per endpoint, write one to clear, set wins.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ep_stall_r <= `UBDO_RST_EP;
      end else begin
         ep_stall_r <= (ep_stall_r & ~((wr_fire && hit(paddr, `UBDO_OFF_EP_STALL)) ? pwdata[15:0] : 16'h0000))
                       | ((tok_valid && ev.ev_stall) ? (16'h0001 << tok_ep) : 16'h0000);
      end
   end

   // Level interrupt.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(int_stat_r & int_mask_r);
      end
   end

   assign prdata    = prdata_r;
   assign pready    = pready_r;
   assign pslverr   = pslverr_r;
   assign hs_valid  = hs_valid_r;
   assign hs_code   = hs_code_r;
   assign buf_wr_en = buf_wr_r;
   assign irq       = irq_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Helper terms: a token the engine may act on, and one whose received data fits the buffer.
   logic owned_ok;
   logic plain_ok;
   assign owned_ok = tok_valid && status_rd[`UBDO_OWN_BIT] && !status_rd[`UBDO_BUFFER_STALL_ENABLE_BIT] && !tok_err;
   assign plain_ok = owned_ok && tok_pid != `UBDO_PID_IN && tok_len <= {status_rd[1:0], count_mem[tok_desc]};

   // Buffer stall: the answer, the flags, the frozen descriptor and the release by SETUP.
   stall_answer_a: assert property (tok_valid && status_rd[`UBDO_OWN_BIT] && status_rd[`UBDO_BUFFER_STALL_ENABLE_BIT] &&
      tok_pid != `UBDO_PID_SETUP |=> hs_valid && hs_code == hs_stall)
      else $error("buffer stall not answered with stall");
   stall_flags_a: assert property (hs_valid && hs_code == hs_stall |-> ep_stall_r[last_ep_r] &&
      int_stat_r[`UBDO_INT_STALL])
      else $error("stall did not set indicator and interrupt");
   stall_keeps_a: assert property (tok_valid && status_rd[`UBDO_OWN_BIT] && status_rd[`UBDO_BUFFER_STALL_ENABLE_BIT] &&
      tok_pid != `UBDO_PID_SETUP && !(wr_fire && is_desc(paddr)) |=> status_mem[$past(tok_desc)] == $past(status_rd))
      else $error("stalled descriptor changed");
   setup_release_a: assert property (tok_valid && status_rd[`UBDO_OWN_BIT] && status_rd[`UBDO_BUFFER_STALL_ENABLE_BIT] &&
      !tok_err && tok_pid == `UBDO_PID_SETUP && tok_len <= {status_rd[1:0], count_mem[tok_desc]} &&
      (!status_rd[`UBDO_TOGGLE_CHECK_ENABLE_BIT] || tok_odd == status_rd[`UBDO_DTS_BIT])
      |=> hs_code == hs_ack && !status_mem[$past(tok_desc)][`UBDO_OWN_BIT])
      else $error("setup did not lift the stall");

   // Toggle checking, errored packets and accepted packets.
   toggle_drop_a: assert property (plain_ok && status_rd[`UBDO_TOGGLE_CHECK_ENABLE_BIT] && tok_odd != status_rd[`UBDO_DTS_BIT]
      |=> hs_code == hs_ack && !buf_wr_en && status_mem[$past(tok_desc)][`UBDO_OWN_BIT] &&
          int_stat_r[`UBDO_INT_MISMATCH] && (!int_stat_r[`UBDO_INT_DONE] || $past(int_stat_r[`UBDO_INT_DONE])))
      else $error("toggle mismatch handled wrongly");
   toggle_free_a: assert property (plain_ok && !status_rd[`UBDO_TOGGLE_CHECK_ENABLE_BIT] && !keep_r
      |=> hs_code == hs_ack && buf_wr_en && !status_mem[$past(tok_desc)][`UBDO_OWN_BIT])
      else $error("unchecked packet not accepted");
   error_nak_a: assert property (owned_ok == 1'b0 && tok_valid && tok_err && status_rd[`UBDO_OWN_BIT] &&
      !status_rd[`UBDO_BUFFER_STALL_ENABLE_BIT] |=> hs_code == hs_nak && !buf_wr_en)
      else $error("errored packet not refused");
   pid_report_a: assert property (plain_ok && (!status_rd[`UBDO_TOGGLE_CHECK_ENABLE_BIT] || tok_odd == status_rd[`UBDO_DTS_BIT])
      |=> status_mem[$past(tok_desc)][5:2] == $past(tok_pid) && int_stat_r[`UBDO_INT_DONE])
      else $error("token pid not reported");
   count_split_a: assert property (plain_ok && !status_rd[`UBDO_TOGGLE_CHECK_ENABLE_BIT]
      |=> {status_mem[$past(tok_desc)][1:0], count_mem[$past(tok_desc)]} == $past(tok_len))
      else $error("byte count not split correctly");
   keep_own_a: assert property (plain_ok && !status_rd[`UBDO_TOGGLE_CHECK_ENABLE_BIT] && keep_r
      |=> status_mem[$past(tok_desc)][`UBDO_OWN_BIT])
      else $error("keep option did not hold ownership");

   // Refusals, the outputs that follow every verdict, the interrupt line and the APB ready.
   unowned_nak_a: assert property (tok_valid && !status_rd[`UBDO_OWN_BIT]
      |=> hs_valid && hs_code == hs_nak && !buf_wr_en)
      else $error("token to core-owned descriptor not refused");
   overflow_nak_a: assert property (owned_ok && tok_pid != `UBDO_PID_IN && !wr_fire &&
      tok_len > {status_rd[1:0], count_mem[tok_desc]}
      |=> hs_code == hs_nak && status_mem[$past(tok_desc)] == $past(status_rd))
      else $error("oversized packet not refused");
   buf_wr_gate_a: assert property (buf_wr_en
      |-> hs_valid && hs_code == hs_ack)
      else $error("buffer write without an accepting handshake");
   verdict_log_a: assert property (hs_valid
      |-> $past(tok_valid) && last_r[11:10] == hs_code)
      else $error("verdict without token or not logged");
   irq_level_a: assert property ((|(int_stat_r & int_mask_r))
      |=> irq)
      else $error("interrupt not raised for an unmasked flag");
   irq_quiet_a: assert property (!(|(int_stat_r & int_mask_r))
      |=> !irq)
      else $error("interrupt raised with no unmasked flag");
   ready_pulse_a: assert property (pready
      |=> !pready)
      else $error("ready held longer than one cycle");

   // Main scenarios that must be seen at least once.
   stall_seen_c:    cover property (hs_valid && hs_code == hs_stall);
   mismatch_seen_c: cover property (tok_valid && ev.ev_mismatch);
   accept_seen_c:   cover property (tok_valid && ev.ev_done ##2 irq);
   keep_seen_c:     cover property (owned_ok && keep_r ##1 hs_code == hs_ack);
   release_seen_c:  cover property (tok_valid && status_rd[`UBDO_BUFFER_STALL_ENABLE_BIT] && tok_pid == `UBDO_PID_SETUP && ev.upd);

endmodule : ubdo_top

// *** dv/ubdo_sie_model.sv ***
// Purpose: Engine-side token source facing the descriptor block.
// Assumes: One token at a time, started by the bench.
// Notes:   Released lines show the inverse of their last value.
`timescale 1ns/100ps
module ubdo_sie_model
   import ubdo_pkg::*;
(
   // Clock and verdict.
   input  wire logic     pclk,
   input  wire logic     hs_valid,
   input  wire ubdo_hs_t hs_code,
   input  wire logic     buf_wr_en,
   // Token port.
   output logic          tok_valid,
   output logic [3:0]    tok_pid,
   output logic [5:0]    tok_desc,
   output logic [3:0]    tok_ep,
   output logic          tok_odd,
   output logic          tok_err,
   output logic [9:0]    tok_len
);
   // Idle values at time zero.
   initial begin
      {tok_valid, tok_pid, tok_desc, tok_ep, tok_odd, tok_err, tok_len} = '0;
   end

   // Sends one token and returns the verdict of the cycle after it.
   task automatic send(input logic [3:0] p, input logic [5:0] d, input logic o, input logic e,
                       input logic [9:0] l, output ubdo_hs_t h, output logic w);
      @(posedge pclk);
      tok_valid <= 1'b1;
      tok_pid   <= p;
      tok_desc  <= d;
      tok_ep    <= d[3:0];
      tok_odd   <= o;
      tok_err   <= e;
      tok_len   <= l;
      @(posedge pclk);
      tok_valid <= 1'b0;
      tok_pid   <= ~p;
      tok_desc  <= ~d;
      tok_ep    <= ~d[3:0];
      tok_odd   <= ~o;
      tok_err   <= ~e;
      tok_len   <= ~l;
      @(posedge pclk);
      h = hs_valid ? hs_code : hs_none;
      w = buf_wr_en;
   endtask : send
endmodule : ubdo_sie_model

// *** dv/ubdo_top_tb_top.sv ***
// Purpose: Self-checking bench of the descriptor ownership block.
// Assumes: APB master and engine model share pclk.
// Notes:   Random descriptors and tokens from a fixed xorshift seed.
`timescale 1ns/100ps
`include "ubdo_defs.svh"
module ubdo_top_tb_top
   import ubdo_pkg::*;
;
   logic        pclk = 1'b0, presetn = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rdat, seed = 32'hde4b38aa;
   logic        pready, pslverr, rerr, tok_valid, tok_odd, tok_err, hs_valid, buf_wr_en, irq;
   logic [3:0]  tok_pid, tok_ep;
   logic [5:0]  tok_desc;
   logic [9:0]  tok_len;
   ubdo_hs_t    hs_code;
   int          miscompares = 0, cmp_count = 0;

   ubdo_top ubdo_top_inst (.*);
   ubdo_sie_model ubdo_sie_model_inst (.*);

   // Clock, 8 ns period.
   initial begin
      forever #4 pclk = ~pclk;
   end

   // Watchdog against a hung handshake.
   initial begin
      #100000;
      miscompares++;
      wrap_up();
   end

   // Next xorshift value.
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   // Expected verdict, descriptor and events of one token.
   function automatic void pred(input logic [7:0] s, input logic [7:0] c, input logic [3:0] p,
                                input logic o, input logic e, input logic k, input logic [9:0] l,
                                output ubdo_hs_t h, output logic [7:0] ns, output logic [7:0] nc,
                                output logic w, output logic [2:0] iv);
      {ns, nc, w, iv} = {s, c, 1'b0, 3'h0};
      h = hs_ack;
      if (!s[7]) h = hs_nak;
      else if (s[2] && p != `UBDO_PID_SETUP) begin
         h  = hs_stall;
         iv = 3'h2;
      end
      else if (e || (p != `UBDO_PID_IN && l > {s[1:0], c})) h = hs_nak;
      else if (p != `UBDO_PID_IN && s[3] && o != s[6]) iv = 3'h4;
      else {ns, nc, w, iv} = {k & !s[2], s[6], p, l[9:8], l[7:0], p != `UBDO_PID_IN, 3'h1};
   endfunction : pred

   // Compares one value.
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   // One APB transfer; result lands in rdat and rerr.
   task automatic apb(input int w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, 1'(w), a, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1); // Only the watchdog ends a hung transfer.
      {rdat, rerr} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
   endtask : apb

   // Prints counts and the verdict.
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : wrap_up

   // Main sequence.
   initial begin
      logic [31:0] r, q;
      logic [7:0]  s, c, ns, nc;
      logic [3:0]  p;
      logic [9:0]  l;
      logic [2:0]  iv;
      logic [11:0] a;
      logic [5:0]  d;
      logic        w, ew, o, e;
      ubdo_hs_t    h, eh;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         apb(0, `UBDO_OFF_INT_STAT + 12'(4 * i), 32'h0);
         chk({rdat[30:0], rerr}, 32'(i == 5));
      end
      $display("test reset_map done");
      apb(1, `UBDO_OFF_INT_MASK, 32'h5);
      for (int i = 0; i < 60; i++) begin
         r = rnd();
         q = rnd();
         d = 6'(i * 37); // Each descriptor is armed once, so never rewritten while owned.
         a = {3'h0, d, 3'h0};
         apb(1, `UBDO_OFF_CTRL, 32'(q[0]));
         s = {i != 0, r[6], 2'b00, r[3], r[2] & r[9], r[1:0]};
         p = q[12:11] == 0 ? `UBDO_PID_OUT : q[12] ? `UBDO_PID_IN : `UBDO_PID_SETUP;
         {o, e} = {q[13], q[14] & q[15] & (i > 3)};
         // Corner cases: SETUP and IN to a stalled buffer, then a toggle mismatch.
         if (i == 1) {s[3:2], p} = {2'b01, `UBDO_PID_SETUP};
         if (i == 2) {s[2], p} = {1'b1, `UBDO_PID_IN};
         if (i == 3) {s[3:2], p, o} = {2'b10, `UBDO_PID_OUT, ~r[6]};
         c = r[15:8];
         apb(1, a | 12'h4, 32'(c));
         apb(1, a, 32'(s));
         apb(0, a, 32'h0);
         chk(rdat, 32'(s));
         l = (r[31] || i < 4) ? {s[1:0], c} : q[10:1];
         pred(s, c, p, o, e, q[0], l, eh, ns, nc, ew, iv);
         ubdo_sie_model_inst.send(p, d, o, e, l, h, w);
         chk(32'(h), 32'(eh));
         chk(32'(w), 32'(ew));
         apb(0, a, 32'h0);
         chk(rdat, 32'(ns));
         apb(0, a | 12'h4, 32'h0);
         chk(rdat, 32'(nc));
         apb(0, `UBDO_OFF_INT_STAT, 32'h0);
         chk(rdat, 32'(iv));
         chk(32'(irq), 32'(|(iv & 3'h5)));
         apb(0, `UBDO_OFF_LAST, 32'h0);
         chk(rdat, 32'({eh, p, d}));
         apb(1, `UBDO_OFF_INT_STAT, 32'h7);
         apb(0, `UBDO_OFF_EP_STALL, 32'h0);
         chk(rdat, iv[1] ? 32'h1 << d[3:0] : 32'h0);
         chk(32'(irq), 32'h0);
         apb(1, `UBDO_OFF_EP_STALL, 32'hffff);
      end
      $display("test tokens done");
      wrap_up();
   end
endmodule : ubdo_top_tb_top
